// ===== src/adcr_clkdiv.sv
`timescale 1ns/1ps
module adcr_clkdiv
  import adcr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        src_tick,
  input  wire logic [2:0]  prescale,
  output logic             div_tick
);

  logic [3:0] cnt_reg;
  logic [3:0] last_cnt;
  logic       wrap;

  // Any code with the top bit set divides by sixteen.
  assign last_cnt = prescale[2] ? DIV16_LAST : ((4'h1 << prescale[1:0]) - 4'h1);
  assign wrap     = src_tick & (cnt_reg >= last_cnt);

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_reg  <= 4'h0;
      div_tick <= 1'b0;
    end
    else
    begin
      div_tick <= wrap;
      if (wrap)
        cnt_reg <= 4'h0;
      else if (src_tick)
        cnt_reg <= cnt_reg + 4'h1;
    end
  end

endmodule // adcr_clkdiv

// ===== src/adcr_pkg.sv
package adcr_pkg;

  // Register byte offsets on the APB bus.
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam logic [7:0]  OFF_STATUS  = 8'h00;
  localparam logic [7:0]  OFF_RES_HI  = 8'h04;
  localparam logic [7:0]  OFF_RES_LO  = 8'h08;
  localparam logic [7:0]  OFF_CLKCFG  = 8'h0C;

  // Status and control field layout.
  localparam int          SC_DONE_BIT = 7;
  localparam int          SC_IRQ_BIT  = 6;
  localparam int          SC_CONT_BIT = 5;
  localparam int          CH_W        = 5;
  localparam logic [7:0]  SC_RESET    = 8'h1F;

  // Channel codes.
  localparam int          NUM_EXT     = 24;
  localparam logic [4:0]  CH_LAST_EXT = 5'h17;
  localparam logic [4:0]  CH_REF_HIGH = 5'h1D;
  localparam logic [4:0]  CH_REF_LOW  = 5'h1E;
  localparam logic [4:0]  CH_POWER_OFF = 5'h1F;

  // Clock configuration field layout.
  localparam int          CK_PRE_MSB  = 7;
  localparam int          CK_PRE_LSB  = 5;
  localparam int          CK_SEL_BIT  = 4;
  localparam int          CK_MODE_MSB = 3;
  localparam int          CK_MODE_LSB = 2;
  localparam logic [7:0]  CK_RESET    = 8'h04;
  localparam logic [7:0]  CK_WR_MASK  = 8'hFC;

  // Justification modes.
  localparam logic [1:0]  MODE_TRUNC  = 2'h0;
  localparam logic [1:0]  MODE_RIGHT  = 2'h1;
  localparam logic [1:0]  MODE_LEFT   = 2'h2;
  localparam logic [1:0]  MODE_LSIGN  = 2'h3;

  // Prescaler: last count of the divide-by-16 setting.
  localparam logic [3:0]  DIV16_LAST  = 4'hF;

  // Conversion length in converter clock ticks, and with one settling conversion added.
  localparam int          RES_W       = 10;
  localparam logic [5:0]  CONV_TICKS  = 6'h11;
  localparam logic [5:0]  WARM_TICKS  = 6'h22;

  typedef enum logic {
    ST_IDLE,
    ST_CONV
  } adcr_state_t;

  // Control bundle towards the analog core.
  typedef struct packed {
    logic                power_down;
    logic                converting;
    logic                ref_high_sel;
    logic                ref_low_sel;
    logic [NUM_EXT-1:0]  in_select;
  } adcr_core_ctl_t;

endpackage

// ===== src/adcr_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Interrupts off: done flag sets per conversion, clears on data read, reset clears.
// - Interrupts on: done flag never sets and reads back zero.
// - Interrupts on: request per conversion, dropped by data read or control write.
// - Continuous bit converts back to back; cleared, one conversion per control write.
// - Five-bit channel field; codes 0 to 23 select the external inputs.
// - Codes 11101 and 11110 convert the high and low internal references.
// - All-ones channel powers the converter down; one settling conversion afterwards.
// - Unused codes 11000 to 11100 give an undefined result.
// - Left mode: top eight bits high, bottom two bits low, rest zero.
// - Right mode: top two bits high, rest zero; bottom eight bits low.
// - Left signed mode: as left mode with result bit nine inverted.
// - Truncation: top eight bits in low register, high reads zero, no interlock.
// - Ten-bit modes: high read freezes low until low read; results meanwhile dropped.
// - Three-bit prescaler divides by 1, 2, 4, 8, or 16 with top bit set.
// - Clock select one picks bus clock, zero the oscillator; reset picks oscillator.
// - Mode bits: 00 truncate, 01 right, 10 left, 11 left signed; reset right.
// - Control writes to any channel but all-ones start a conversion of 16 to 17 converter clocks, 33 to 34 with settling.
// - Stop mode aborts any conversion and keeps the converter inactive.
module adcr_top
  import adcr_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              oscillator_clock,
  input  wire logic              stop_mode,
  input  wire logic [RES_W-1:0]  core_result,
  output adcr_core_ctl_t         core_ctl,
  output logic                   conv_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [CH_W-1:0]   channel_select_reg;
  logic              conv_irq_enable_reg;
  logic              continuous_conv_reg;
  logic              conversion_done_flag_reg;
  logic [2:0]        clock_prescale_reg;
  logic              input_clock_select_reg;
  logic [1:0]        justify_sel_reg;
  logic [7:0]        result_high_reg;
  logic [7:0]        result_low_reg;
  logic              lock_reg;

  adcr_state_t       state_reg;
  logic [5:0]        tick_cnt_reg;
  logic [5:0]        target_reg;
  logic              start_pend_reg;
  logic              warm_reg;
  logic              stop_prev_reg;

  logic [2:0]        osc_sync_reg;
  logic              osc_level_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode. Every access takes one wait state so that all outputs stay registered.

  logic              acc;
  logic              do_acc;
  logic              wr;
  logic              rd;
  logic              sel_sc;
  logic              sel_hi;
  logic              sel_lo;
  logic              sel_ck;
  logic              addr_ok;
  logic              wr_sc;
  logic              wr_ck;
  logic              rd_hi;
  logic              rd_lo;
  logic              rd_data;
  logic              pready_next;

  assign acc         = psel & penable;
  assign do_acc      = acc & pready;
  assign wr          = do_acc & pwrite;
  assign rd          = do_acc & ~pwrite;
  assign sel_sc      = (paddr == OFF_STATUS);
  assign sel_hi      = (paddr == OFF_RES_HI);
  assign sel_lo      = (paddr == OFF_RES_LO);
  assign sel_ck      = (paddr == OFF_CLKCFG);
  assign addr_ok     = sel_sc | sel_hi | sel_lo | sel_ck;
  assign wr_sc       = wr & sel_sc;
  assign wr_ck       = wr & sel_ck;
  assign rd_hi       = rd & sel_hi;
  assign rd_lo       = rd & sel_lo;
  assign rd_data     = rd_hi | rd_lo;
  assign pready_next = acc & ~pready;

  ////////////////////////////////////////////////////////////////////////////////
  // Read data mux. The done flag is masked while interrupts are enabled.

  logic              flag_visible;
  logic [7:0]        sc_read;
  logic [7:0]        ck_read;
  logic [7:0]        rd_byte;

  assign flag_visible = conversion_done_flag_reg & ~conv_irq_enable_reg;
  assign sc_read = {flag_visible, conv_irq_enable_reg, continuous_conv_reg, channel_select_reg};
  assign ck_read = {clock_prescale_reg, input_clock_select_reg, justify_sel_reg, 2'h0};
  assign rd_byte = sel_sc ? sc_read :
                   sel_hi ? result_high_reg :
                   sel_lo ? result_low_reg :
                   sel_ck ? ck_read : 8'h00;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= pready_next;
      pslverr <= pready_next & ~addr_ok;
      if (pready_next & ~pwrite)
        prdata <= {24'h00_0000, rd_byte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers.

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      channel_select_reg     <= SC_RESET[CH_W-1:0];
      conv_irq_enable_reg    <= SC_RESET[SC_IRQ_BIT];
      continuous_conv_reg    <= SC_RESET[SC_CONT_BIT];
      clock_prescale_reg     <= CK_RESET[CK_PRE_MSB:CK_PRE_LSB];
      input_clock_select_reg <= CK_RESET[CK_SEL_BIT];
      justify_sel_reg        <= CK_RESET[CK_MODE_MSB:CK_MODE_LSB];
    end
    else
    begin
      // The done flag position of the written byte is not stored.
      if (wr_sc)
      begin
        channel_select_reg  <= pwdata[CH_W-1:0];
        conv_irq_enable_reg <= pwdata[SC_IRQ_BIT];
        continuous_conv_reg <= pwdata[SC_CONT_BIT];
      end
      if (wr_ck)
      begin
        clock_prescale_reg     <= pwdata[CK_PRE_MSB:CK_PRE_LSB];
        input_clock_select_reg <= pwdata[CK_SEL_BIT];
        justify_sel_reg        <= pwdata[CK_MODE_MSB:CK_MODE_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Converter clock source. The oscillator arrives from another domain, so only a
  // level on which the second and third stages agree counts as a rising edge.

  logic              osc_agree;
  logic              osc_rise;
  logic              src_tick;
  logic              div_tick;

  assign osc_agree = (osc_sync_reg[1] == osc_sync_reg[2]);
  assign osc_rise  = osc_agree & osc_sync_reg[2] & ~osc_level_reg;
  assign src_tick  = input_clock_select_reg ? 1'b1 : osc_rise;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      osc_sync_reg  <= 3'h0;
      osc_level_reg <= 1'b0;
    end
    else
    begin
      osc_sync_reg <= {osc_sync_reg[1:0], oscillator_clock};
      if (osc_agree)
        osc_level_reg <= osc_sync_reg[2];
    end
  end

  adcr_clkdiv u_clkdiv (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .src_tick (src_tick),
    .prescale (clock_prescale_reg),
    .div_tick (div_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer. The divider runs free, so the partial first tick makes a
  // conversion of seventeen ticks last between sixteen and seventeen clock periods.

  logic              pwr_off;
  logic              stop_exit;
  logic              go;
  logic              complete;

  assign pwr_off   = (channel_select_reg == CH_POWER_OFF);
  assign stop_exit = stop_prev_reg & ~stop_mode;
  assign go        = start_pend_reg & ~pwr_off & ~stop_mode & ~wr_sc;
  assign complete  = (state_reg == ST_CONV) & div_tick & ~wr_sc & ~stop_mode
                   & (tick_cnt_reg == (target_reg - 6'h01));

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg      <= ST_IDLE;
      tick_cnt_reg   <= 6'h00;
      target_reg     <= CONV_TICKS;
      start_pend_reg <= 1'b0;
      warm_reg       <= 1'b1;
      stop_prev_reg  <= 1'b0;
    end
    else
    begin
      stop_prev_reg <= stop_mode;
      if (pwr_off | stop_mode)
        warm_reg <= 1'b1;
      else if (go)
        warm_reg <= 1'b0;
      if (wr_sc)
      begin
        // Abandon whatever is running and start again on the new channel.
        state_reg      <= ST_IDLE;
        tick_cnt_reg   <= 6'h00;
        start_pend_reg <= 1'b1;
      end
      else if (stop_mode)
      begin
        state_reg    <= ST_IDLE;
        tick_cnt_reg <= 6'h00;
      end
      else if (stop_exit & continuous_conv_reg)
        start_pend_reg <= 1'b1;
      else
      begin
        case (state_reg)
          ST_IDLE:
          begin
            if (go)
            begin
              state_reg      <= ST_CONV;
              start_pend_reg <= 1'b0;
              tick_cnt_reg   <= 6'h00;
              target_reg     <= warm_reg ? WARM_TICKS : CONV_TICKS;
            end
            else if (pwr_off)
              start_pend_reg <= 1'b0;
          end
          ST_CONV:
          begin
            if (complete)
            begin
              tick_cnt_reg <= 6'h00;
              target_reg   <= CONV_TICKS;
              if (!continuous_conv_reg)
                state_reg <= ST_IDLE;
            end
            else if (div_tick)
              tick_cnt_reg <= tick_cnt_reg + 6'h01;
          end
          default:
            state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result formatting and the high/low read interlock.

  logic              ten_bit;
  logic              store;
  logic [7:0]        hi_fmt;
  logic [7:0]        lo_fmt;
  logic [7:0]        left_hi;

  // Codes 11000 to 11100 drive no input, so whatever the core returns is stored as is.
  assign ten_bit = (justify_sel_reg != MODE_TRUNC);
  assign store   = complete & ~(ten_bit & (lock_reg | rd_hi));
  assign left_hi = core_result[RES_W-1:2];
  assign hi_fmt  = (justify_sel_reg == MODE_TRUNC) ? 8'h00 :
                   (justify_sel_reg == MODE_RIGHT) ? {6'h00, core_result[9:8]} :
                   (justify_sel_reg == MODE_LEFT)  ? left_hi :
                   {~left_hi[7], left_hi[6:0]};
  assign lo_fmt  = (justify_sel_reg == MODE_TRUNC) ? core_result[RES_W-1:2] :
                   (justify_sel_reg == MODE_RIGHT) ? core_result[7:0] :
                   {core_result[1:0], 6'h00};

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      result_high_reg <= 8'h00;
      result_low_reg  <= 8'h00;
      lock_reg        <= 1'b0;
    end
    else
    begin
      if (store)
      begin
        result_high_reg <= hi_fmt;
        result_low_reg  <= lo_fmt;
      end
      if (rd_lo | ~ten_bit)
        lock_reg <= 1'b0;
      else if (rd_hi)
        lock_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Completion flag and interrupt request. A completion in the same cycle as the
  // clearing data read wins, so no event is lost.

  logic              flag_next;
  logic              irq_next;

  assign flag_next = (complete & ~conv_irq_enable_reg) ? 1'b1 :
                     rd_data ? 1'b0 : conversion_done_flag_reg;
  assign irq_next  = ((complete & conv_irq_enable_reg) ? 1'b1 :
                      (rd_data | wr_sc) ? 1'b0 : conv_irq)
                   & (wr_sc ? pwdata[SC_IRQ_BIT] : conv_irq_enable_reg);

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      conversion_done_flag_reg <= 1'b0;
      conv_irq                 <= 1'b0;
    end
    else
    begin
      conversion_done_flag_reg <= flag_next;
      conv_irq                 <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Analog multiplexer and power control.

  logic [NUM_EXT-1:0] ext_sel;
  adcr_core_ctl_t     ctl_next;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT; gi = gi + 1)
    begin : g_ext
      assign ext_sel[gi] = (channel_select_reg == CH_W'(gi));
    end
  endgenerate

  assign ctl_next.power_down   = pwr_off | stop_mode;
  assign ctl_next.converting   = (state_reg == ST_CONV) & ~stop_mode;
  assign ctl_next.ref_high_sel = (channel_select_reg == CH_REF_HIGH);
  assign ctl_next.ref_low_sel  = (channel_select_reg == CH_REF_LOW);
  assign ctl_next.in_select    = ext_sel & {NUM_EXT{~stop_mode}};

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      core_ctl <= '0;
    else
      core_ctl <= ctl_next;
  end

endmodule // adcr_top

// ===== verification/adcr_core_model.sv
`timescale 1ns/1ps
module adcr_core_model
  import adcr_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           rst_b,
  input  wire adcr_core_ctl_t core_ctl,
  output logic [RES_W-1:0]    core_result,
  output logic [4:0]          conv_count
);
  logic             conv_d;
  logic [RES_W-1:0] idle_pat;
  logic [4:0]       code;

  // Outside a conversion the result lines toggle, so a stale sample shows up.
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      conv_d     <= 1'b0;
      conv_count <= 5'h00;
      idle_pat   <= 10'h155;
    end
    else
    begin
      conv_d   <= core_ctl.converting;
      idle_pat <= ~idle_pat;
      if (core_ctl.converting && !conv_d)
        conv_count <= conv_count + 5'h01;
    end

  always_comb
  begin
    code = 5'h00;
    for (int k = 0; k < NUM_EXT; k++)
      if (core_ctl.in_select[k])
        code = k[4:0];
  end

  assign core_result = !core_ctl.converting ? idle_pat :
                       core_ctl.ref_high_sel ? 10'h3FF :
                       core_ctl.ref_low_sel  ? 10'h000 : {code, conv_count};
endmodule // adcr_core_model

// ===== verification/adcr_top_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module adcr_top_bench
  import adcr_pkg::*;
;
  logic              mclk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic              oscillator_clock, stop_mode, conv_irq, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [RES_W-1:0]  core_result, r;
  logic [4:0]        conv_count;
  adcr_core_ctl_t    core_ctl;
  int                failures = 0;
  int                n_tests = 0;
  int                cyc = 0;

  adcr_top uut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .oscillator_clock(oscillator_clock), .stop_mode(stop_mode),
    .core_result(core_result), .core_ctl(core_ctl), .conv_irq(conv_irq));
  adcr_core_model model (.mclk(mclk), .rst_b(rst_b), .core_ctl(core_ctl),
    .core_result(core_result), .conv_count(conv_count));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // The oscillator runs at a quarter of the bus rate, out of phase with it.
  initial
  begin
    oscillator_clock = 1'b0;
    #7;
    forever #20 oscillator_clock = ~oscillator_clock;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      failures++;
      complete_run();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    // Only the bench timeout ends this wait; the slave sets its own pace.
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr_sc(input logic [7:0] d);
    apb(1'b1, OFF_STATUS, d & 8'h7F);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(rd, {24'h000000, e})
  endtask
  task automatic wait_flag();
    int n;
    n = 0;
    do begin apb(1'b0, OFF_STATUS, 8'h00); n++; end while (rd[7] !== 1'b1 && n < 200);
    if (n >= 200)
    begin
      failures++;
      complete_run();
    end
  endtask
  task automatic wait_irq(output int n);
    // Step an edge first: the caller returns in the time step of the edge that
    // clears the request, where the old level is still visible.
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (conv_irq !== 1'b1 && n < 2000);
    if (n >= 2000)
    begin
      failures++;
      complete_run();
    end
  endtask
  function automatic logic [9:0] res(logic [4:0] ch);
    return ch == CH_REF_HIGH ? 10'h3FF : ch == CH_REF_LOW ? 10'h000 : {ch, conv_count};
  endfunction
  function automatic logic [15:0] fmt(logic [1:0] m, logic [9:0] v);
    case (m)
      MODE_TRUNC: return {8'h00, v[9:2]};
      MODE_RIGHT: return {6'h00, v[9:0]};
      MODE_LEFT:  return {v[9:2], v[1:0], 6'h00};
      default:    return {~v[9], v[8:2], v[1:0], 6'h00};
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(OFF_STATUS, SC_RESET);
    rd_chk(OFF_CLKCFG, CK_RESET);
    apb(1'b0, 8'h10, 8'h00);
    `CHK({err, rd}, {1'b1, 32'h00000000})
  endtask
  task automatic t_modes();
    logic [4:0] ch;
    logic [15:0] e;
    for (int i = 0; i < 26; i++)
    begin
      ch = i < 24 ? i[4:0] : (i == 24 ? CH_REF_HIGH : CH_REF_LOW);
      apb(1'b1, OFF_CLKCFG, {4'b0001, i[1:0], 2'b00});
      wr_sc({3'b000, ch});
      wait_flag();
      e = fmt(i[1:0], res(ch));
      rd_chk(OFF_RES_HI, e[15:8]);
      rd_chk(OFF_RES_LO, e[7:0]);
      rd_chk(OFF_STATUS, {3'b000, ch});
    end
  endtask
  task automatic t_irq();
    int n;
    apb(1'b1, OFF_CLKCFG, 8'h14);
    wr_sc(8'h42);
    wait_irq(n);
    rd_chk(OFF_STATUS, 8'h42);
    `CHK(conv_irq, 1'b1)
    apb(1'b0, OFF_RES_HI, 8'h00);
    @(posedge mclk);
    `CHK(conv_irq, 1'b0)
    apb(1'b0, OFF_RES_LO, 8'h00);
  endtask
  task automatic t_prescale();
    int n;
    int dv[6] = '{1, 2, 4, 8, 16, 16};
    logic [2:0] pc[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, OFF_CLKCFG, i < 6 ? {pc[i], 5'h14} : 8'h04);
      wr_sc(8'h42);
      wait_irq(n);
      wr_sc(8'h42);
      wait_irq(n);
      if (i < 6)
        `CHK(n >= 16 * dv[i] && n <= 18 * dv[i] + 4, 1'b1)
      else
        `CHK(n >= 64 && n <= 84, 1'b1)
    end
    wr_sc(8'h1F);
    repeat (3) @(posedge mclk);
    `CHK({core_ctl.power_down, conv_irq}, 2'b10)
  endtask
  task automatic t_lock();
    apb(1'b1, OFF_CLKCFG, 8'h18);
    wr_sc(8'h03);
    wait_flag();
    r = res(5'h03);
    rd_chk(OFF_RES_HI, r[9:2]);
    wr_sc(8'h03);
    wait_flag();
    rd_chk(OFF_RES_LO, {r[1:0], 6'h00});
    rd_chk(OFF_RES_HI, r[9:2]);
    apb(1'b0, OFF_RES_LO, 8'h00);
  endtask
  task automatic t_cont();
    apb(1'b1, OFF_CLKCFG, 8'h14);
    wr_sc(8'h24);
    wait_flag();
    apb(1'b0, OFF_RES_LO, 8'h00);
    wait_flag();
    `CHK(rd, 32'h0000_00A4)
    wr_sc(8'h1F);
    apb(1'b0, OFF_RES_LO, 8'h00);
  endtask
  task automatic t_stop();
    wr_sc(8'h06);
    repeat (5) @(posedge mclk);
    stop_mode <= 1'b1;
    repeat (40) @(posedge mclk);
    `CHK(core_ctl.converting, 1'b0)
    stop_mode <= 1'b0;
    repeat (100) @(posedge mclk);
    rd_chk(OFF_STATUS, 8'h06);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; stop_mode = 1'b0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_modes();
    t_irq();
    t_prescale();
    t_lock();
    t_cont();
    t_stop();
    complete_run();
  end
endmodule // adcr_top_bench

// ===== verification/adcr_top_props.sv
`timescale 1ns/1ps
module adcr_top_props
  import adcr_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              stop_mode,
  input wire adcr_core_ctl_t    core_ctl,
  input wire logic              conv_irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  wire acc    = psel && penable && pready;
  wire mapped = (paddr == OFF_STATUS) || (paddr == OFF_RES_HI) ||
                (paddr == OFF_RES_LO) || (paddr == OFF_CLKCFG);
  wire rd_res = acc && !pwrite && ((paddr == OFF_RES_HI) || (paddr == OFF_RES_LO));

  //////////////////////////////////////////////////////////////////////////////
  chk_apb_wait_state: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("access did not complete after one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  chk_slverr_map: assert property (acc |-> (pslverr == !mapped))
    else $error("error response does not match address decode");
  chk_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("read data has nonzero upper bits");
  chk_flag_masked: assert property (
    acc && !pwrite && paddr == OFF_STATUS && prdata[SC_IRQ_BIT] |-> !prdata[SC_DONE_BIT])
    else $error("done flag set while interrupt enabled");
  chk_irq_wr_drop: assert property (acc && pwrite && paddr == OFF_STATUS |=> !conv_irq)
    else $error("interrupt not dropped by control write");
  chk_irq_rd_drop: assert property (rd_res |=> !conv_irq || core_ctl.converting)
    else $error("interrupt not dropped by data read");
  chk_stop_abort: assert property (stop_mode [*2] |=> !core_ctl.converting)
    else $error("converter active in stop mode");
  chk_power_quiet: assert property (
    core_ctl.power_down |-> !core_ctl.converting && core_ctl.in_select == 24'h000000)
    else $error("powered down converter still active");
  chk_sel_onehot: assert property (
    $onehot0({core_ctl.ref_high_sel, core_ctl.ref_low_sel, core_ctl.in_select}))
    else $error("more than one input selected");

  cov_irq: cover property ($rose(conv_irq));
  cov_unmapped: cover property (acc && !mapped);
  cov_stop: cover property (stop_mode && core_ctl.converting);
endmodule // adcr_top_props

bind adcr_top adcr_top_props chk_i (.mclk(mclk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .stop_mode(stop_mode), .core_ctl(core_ctl), .conv_irq(conv_irq));
